// file: dv/vds_proc_model.sv
// Purpose: Processor-side model that drives the identification code inputs.
// Assumes: Changes are launched on the falling edge of mclk.
// Notes: Only the glitch task breaks the spacing, and a scenario asks for it.

`timescale 1ns/1ps
`default_nettype none

module vds_proc_model #(
    parameter int unsigned MIN_GAP = 100 // Cycles between changes, 1 us at 100 MHz.
) (
    input wire logic mclk, // System clock.
    output logic [7:0] voltage_id_inputs // Code driven toward the block.
);
    // Present code and the number of cycles since set_code last changed it.
    logic [7:0] code_q = 8'h10;
    int unsigned since_q = 0;

    assign voltage_id_inputs = code_q;

    // Age counter used to keep changes apart.
    always @(posedge mclk) begin
        since_q++;
    end

    // Moves the code, first waiting out the minimum spacing.
    task automatic set_code(input logic [7:0] c);
        @(negedge mclk);
        while (since_q < MIN_GAP) begin
            @(negedge mclk);
        end
        code_q = c;
        since_q = 0;
    endtask

    // Moves the code by exactly one table step.
    task automatic step(input logic up);
        set_code(up ? code_q + 8'h01 : code_q - 8'h01);
    endtask

    // Shows a value for n cycles only, then returns to the old code.
    task automatic glitch(input logic [7:0] c, input int n);
        logic [7:0] old;
        @(negedge mclk);
        old = code_q;
        code_q = c;
        repeat (n) @(negedge mclk);
        code_q = old;
    endtask
endmodule

`default_nettype wire

// file: dv/vds_top_test.sv
// Purpose: Self-checking bench for the code front end.
// Assumes: Short dividers keep the run brief; expectations follow them.
// Notes: Inputs move on the falling edge so each rising edge sees them settled.

`timescale 1ns/1ps
`default_nettype none

module vds_top_test;
    localparam int unsigned SDIV = 4; // Shortened sample divider.
    localparam int unsigned PDIV = 8; // Shortened stepping divider.

    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic enable = 1'b1;
    vds_pkg::vds_mode_t table_mode = vds_pkg::VDS_MODE_8BIT;
    wire logic [7:0] voltage_id_inputs;
    logic [8:0] dac_code;
    logic [8:0] target_code;
    vds_pkg::vds_status_t status;
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;

    vds_top #(.SAMPLE_DIV(SDIV), .STEP_DIV(PDIV)) DUT (
        .mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .enable(enable),
        .table_mode(table_mode), .voltage_id_inputs(voltage_id_inputs),
        .dac_code(dac_code), .target_code(target_code), .status(status)
    );

    vds_proc_model PROC (.mclk(mclk), .voltage_id_inputs(voltage_id_inputs));

    // Free-running 100 MHz clock.
    always #5 mclk = ~mclk;

    // A hang is cut short well past the longest expected run.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 30000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One comparison; four-state so an unknown never matches.
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Waits a bounded number of cycles for the reference to reach a level.
    task automatic wait_dac(input logic [8:0] exp, input int max);
        for (int i = 0; i < max && dac_code !== exp; i++) @(negedge mclk);
    endtask

    // After reset the first stable code is taken; then a single step lands at once.
    task automatic t_jump8();
        logic [8:0] old;
        wait_dac(9'h0f2, 40);
        check(dac_code, 9'h0f2);
        check(target_code, 9'h0f2);
        old = dac_code;
        PROC.step(1'b1);
        repeat (8) @(negedge mclk);
        check(dac_code, old);
        wait_dac(9'h0f1, 8);
        check(dac_code, 9'h0f1);
        check({8'h00, status.slewing}, 9'h000);
    endtask

    // A value seen on fewer than three samples is ignored.
    task automatic t_glitch();
        logic [8:0] old;
        old = dac_code;
        PROC.glitch(8'h30, 2 * SDIV);
        repeat (30) @(negedge mclk);
        check(dac_code, old);
    endtask

    // Large jumps in the 8-bit table are followed in a single load.
    task automatic t_follow8();
        PROC.set_code(8'h40);
        wait_dac(9'h0c2, 20);
        check(dac_code, 9'h0c2);
        PROC.set_code(8'h20);
        wait_dac(9'h0e2, 20);
        check(dac_code, 9'h0e2);
    endtask

    // Slewing tables: target at once, then one level per stepping tick.
    task automatic t_slew(input vds_pkg::vds_mode_t m, input logic [7:0] c, input logic [8:0] exp);
        logic [8:0] prev;
        int gap;
        logic first;
        PROC.set_code(c);
        table_mode = m;
        for (int i = 0; i < 20 && target_code !== exp; i++) @(negedge mclk);
        check(target_code, exp);
        @(negedge mclk);
        check({8'h00, status.slewing}, 9'h001);
        prev = dac_code;
        gap = 0;
        first = 1'b1;
        for (int i = 0; i < 2000 && dac_code !== exp; i++) begin
            @(negedge mclk);
            gap++;
            if (dac_code !== prev) begin
                check(dac_code, (exp > prev) ? prev + 9'h001 : prev - 9'h001);
                if (!first) check(9'(gap), 9'(PDIV));
                first = 1'b0;
                gap = 0;
                prev = dac_code;
            end
        end
        check(dac_code, exp);
        @(negedge mclk);
        check({8'h00, status.slewing}, 9'h000);
    endtask

    // Shutdown code needs four samples, then holds until enable drops.
    // The resume code r must differ from the last accepted code, or it is never taken.
    task automatic t_off(input vds_pkg::vds_mode_t m, input logic [7:0] c, input logic [7:0] r,
                         input logic [8:0] exp);
        logic [8:0] held;
        PROC.set_code(c);
        table_mode = m;
        repeat (12) @(negedge mclk);
        check({8'h00, status.off_latched}, 9'h000);
        for (int i = 0; i < 12 && status.off_latched !== 1'b1; i++) @(negedge mclk);
        check({8'h00, status.off_latched}, 9'h001);
        check({8'h00, status.regulate}, 9'h000);
        held = dac_code;
        PROC.set_code(r);
        repeat (40) @(negedge mclk);
        check(dac_code, held);
        check({8'h00, status.off_latched}, 9'h001);
        enable = 1'b0;
        repeat (3) @(negedge mclk);
        check({8'h00, status.off_latched}, 9'h000);
        enable = 1'b1;
        wait_dac(exp, 400);
        check(dac_code, exp);
        check({8'h00, status.regulate}, 9'h001);
    endtask

    // A frozen clock enable holds everything; release lets the code through.
    task automatic t_freeze();
        logic [8:0] old;
        old = dac_code;
        clk_en = 1'b0;
        PROC.set_code(8'h05);
        repeat (60) @(negedge mclk);
        check(dac_code, old);
        clk_en = 1'b1;
        wait_dac(9'h0e4, 200);
        check(dac_code, 9'h0e4);
    endtask

    // Main sequence: reset for five cycles, then every scenario in turn.
    initial begin
        repeat (5) @(negedge mclk);
        check(dac_code, 9'h000);
        reset_n = 1'b1;
        t_jump8();
        t_glitch();
        t_follow8();
        t_slew(vds_pkg::VDS_MODE_5BIT, 8'h0a, 9'h0d0);
        t_slew(vds_pkg::VDS_MODE_5BIT, 8'h08, 9'h0d8);
        t_slew(vds_pkg::VDS_MODE_6BIT, 8'h30, 9'h05a);
        t_off(vds_pkg::VDS_MODE_8BIT, 8'hfe, 8'h02, 9'h100);
        t_off(vds_pkg::VDS_MODE_5BIT, 8'h1f, 8'h03, 9'h0ec);
        t_freeze();
        tally_and_finish();
    end
endmodule

`default_nettype wire

// file: inc/vds_pkg.sv
// Purpose: Shared constants and types for the identification-code front end.
// Assumes: mclk at 100 MHz; levels count in 6.25 mV units of the reference.
// Notes: Every figure used by more than one file lives here.

package vds_pkg;

    // Clock and sampling rates in hertz.
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned SAMPLE_HZ = 5_500_000;
    localparam int unsigned STEP_HZ = 345_000;

    // Cycle counts derived from the rates; rounding down keeps rates at or above figure.
    localparam int unsigned SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
    localparam int unsigned STEP_DIV = CLK_HZ / STEP_HZ;

    // Consecutive equal samples needed before a code is believed, and where the run count stops.
    localparam logic [2:0] ACCEPT_RUN = 3'h3;
    localparam logic [2:0] OFF_RUN = 3'h4;
    localparam logic [2:0] RUN_MAX = 3'h7;

    // Widths of the code and of the reference level.
    localparam int CODE_W = 8;
    localparam int LEVEL_W = 9;

    // Shutdown codes of the 8-bit and 5-bit tables.
    localparam logic [6:0] VR_OFF_HI = 7'h7f;
    localparam logic [4:0] OFF5_CODE = 5'h1f;

    // 8-bit table: level = top minus code, inside the printed code range.
    localparam logic [9:0] VR_TOP_LEVEL = 10'h102;
    localparam logic [7:0] VR_MIN_CODE = 8'h02;
    localparam logic [7:0] VR_MAX_CODE = 8'hb2;

    // 5-bit and upper 6-bit half: level = top minus four per code step.
    localparam logic [9:0] SLEW_TOP_LEVEL = 10'h0f8;
    // Lower 6-bit half: level = base minus two per code step.
    localparam logic [9:0] SIX_LOW_BASE = 10'h0ba;

    // Input masks per table.
    localparam logic [7:0] MASK_8BIT = 8'hff;
    localparam logic [7:0] MASK_6BIT = 8'h3f;
    localparam logic [7:0] MASK_5BIT = 8'h1f;

    // Reset values.
    localparam logic [8:0] LEVEL_RST = 9'h000;
    localparam logic [7:0] CODE_RST = 8'h00;

    // Selected code table.
    typedef enum logic [1:0] {
        VDS_MODE_8BIT,
        VDS_MODE_5BIT,
        VDS_MODE_6BIT
    } vds_mode_t;

    // Status word presented to the analog side.
    typedef struct packed {
        logic regulate;
        logic off_latched;
        logic slewing;
    } vds_status_t;

endpackage

// file: verilog/vds_sampler.sv
// Purpose: Sample tick generator and run-length counter for the code inputs.
// Assumes: Inputs are synchronous to mclk; clk_en freezes every flop.
// Notes: run counts how many consecutive ticks have seen the present sample.

`timescale 1ns/1ps
`default_nettype none

module vds_sampler #(
    parameter int unsigned SAMPLE_DIV = vds_pkg::SAMPLE_DIV
) (
    input wire logic mclk, // System clock.
    input wire logic reset_n, // Asynchronous reset, active low.
    input wire logic clk_en, // Freezes all state while low.
    input wire logic [7:0] sample_in, // Masked code inputs.
    output logic tick, // One-cycle pulse with freshly updated sample.
    output logic [7:0] sample, // Most recent sampled code.
    output logic [2:0] run // Consecutive samples equal to sample.
);

    logic [7:0] div_q; // Divider toward the next sample.
    logic [7:0] div_d; // Next divider value.
    logic tick_q; // Registered tick pulse.
    logic [7:0] sample_q; // Last sampled value.
    logic [2:0] run_q; // Saturating run length.
    logic fire; // Divider wrap in an enabled cycle.
    logic same; // Input matches the previous sample.

    // The divider wraps every SAMPLE_DIV enabled cycles.
    assign fire = clk_en && (div_q == 8'h00);
    assign div_d = (div_q == 8'h00) ? 8'(SAMPLE_DIV - 1) : div_q - 8'h01;
    assign same = (sample_in == sample_q);

    // Divider and tick; both hold their values while the clock enable is low.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            div_q <= 8'h00;
            tick_q <= 1'b0;
        end else if (clk_en) begin
            div_q <= div_d;
            tick_q <= fire;
        end
    end

    // Sample register and run counter; a new value restarts the run at one.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sample_q <= 8'h00;
            run_q <= 3'h0;
        end else if (fire) begin
            sample_q <= sample_in;
            if (same && run_q != vds_pkg::RUN_MAX) begin
                run_q <= run_q + 3'h1;
            end else if (!same) begin
                run_q <= 3'h1;
            end
        end
    end

    assign tick = tick_q;
    assign sample = sample_q;
    assign run = run_q;

    // Helper: enabled cycles since the last tick, for the period check.
    logic [7:0] gap_q;
    logic seen_q;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            gap_q <= 8'h00;
            seen_q <= 1'b0;
        end else if (clk_en) begin
            gap_q <= tick_q ? 8'h01 : gap_q + 8'h01;
            seen_q <= seen_q | tick_q;
        end
    end

    tick_period_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (clk_en && tick_q && seen_q) |-> (gap_q == 8'(SAMPLE_DIV)))
        else $error("sample tick period wrong");

    run_restart_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (fire && !same) |=> (run_q == 3'h1))
        else $error("run did not restart on new value");

    tick_seen_c: cover property (@(posedge mclk) disable iff (!reset_n)
        tick_q && run_q == 3'h3);

endmodule

`default_nettype wire

// file: verilog/vds_top.sv
// Purpose: Identification-code front end of a multiphase buck controller.
// Assumes: Code inputs synchronous to mclk at 100 MHz; clk_en freezes all state.
// Notes: Levels are in 6.25 mV units; the analog side turns them into a voltage.

`timescale 1ns/1ps
`default_nettype none

module vds_top #(
    parameter int unsigned SAMPLE_DIV = vds_pkg::SAMPLE_DIV,
    parameter int unsigned STEP_DIV = vds_pkg::STEP_DIV
) (
    input wire logic mclk, // System clock, 100 MHz.
    input wire logic reset_n, // Asynchronous reset, active low.
    input wire logic clk_en, // Freezes all state while low.
    input wire logic enable, // Converter enable; low clears the off latch.
    input wire vds_pkg::vds_mode_t table_mode, // Selected code table.
    input wire logic [7:0] voltage_id_inputs, // Code driven by the processor.
    output logic [8:0] dac_code, // Reference level, 6.25 mV units.
    output logic [8:0] target_code, // Validated target level.
    output vds_pkg::vds_status_t status // Regulate, off latch and slewing flags.
);

    // Table flags decoded once.
    logic mode_8; // Direct-jump table.
    logic mode_slew; // Either slewing table.
    logic [7:0] in_mask; // Bits that belong to the selected table.
    logic [7:0] masked_in; // Code with unused bits forced low.

    assign mode_8 = (table_mode == vds_pkg::VDS_MODE_8BIT);
    assign mode_slew = !mode_8;
    assign in_mask = (table_mode == vds_pkg::VDS_MODE_5BIT) ? vds_pkg::MASK_5BIT :
                     (table_mode == vds_pkg::VDS_MODE_6BIT) ? vds_pkg::MASK_6BIT :
                     vds_pkg::MASK_8BIT;
    // Masking keeps stray upper bits from restarting the stability count.
    assign masked_in = voltage_id_inputs & in_mask;

    // Sampler outputs.
    logic smp_tick; // Fresh sample this cycle.
    logic [7:0] smp_val; // Sampled code.
    logic [2:0] smp_run; // Consecutive equal samples.

    vds_sampler #(
        .SAMPLE_DIV(SAMPLE_DIV)
    ) u_sampler (
        .mclk(mclk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .sample_in(masked_in),
        .tick(smp_tick),
        .sample(smp_val),
        .run(smp_run)
    );

    // Converts a code of the selected table into a level.
    function automatic logic [8:0] code_level(input vds_pkg::vds_mode_t m,
                                              input logic [7:0] c);
        logic [9:0] t;
        t = 10'h000;
        case (m)
            vds_pkg::VDS_MODE_8BIT: begin
                // Codes outside the printed range are clamped to its ends.
                if (c < vds_pkg::VR_MIN_CODE) begin
                    t = vds_pkg::VR_TOP_LEVEL - {2'b00, vds_pkg::VR_MIN_CODE};
                end else if (c > vds_pkg::VR_MAX_CODE) begin
                    t = vds_pkg::VR_TOP_LEVEL - {2'b00, vds_pkg::VR_MAX_CODE};
                end else begin
                    t = vds_pkg::VR_TOP_LEVEL - {2'b00, c};
                end
            end
            vds_pkg::VDS_MODE_5BIT: begin
                t = vds_pkg::SLEW_TOP_LEVEL - {3'b000, c[4:0], 2'b00};
            end
            vds_pkg::VDS_MODE_6BIT: begin
                if (c[5]) begin
                    t = vds_pkg::SIX_LOW_BASE - {3'b000, c[5:0], 1'b0};
                end else begin
                    t = vds_pkg::SLEW_TOP_LEVEL - {3'b000, c[4:0], 2'b00};
                end
            end
            default: begin
                t = 10'h000;
            end
        endcase
        return t[8:0];
    endfunction

    // State registers.
    logic [7:0] acc_q; // Last accepted code.
    logic have_q; // A code has been accepted since reset.
    logic [8:0] dac_q; // Present reference level.
    logic [8:0] dac_d;
    logic [8:0] tgt_q; // Target level.
    logic [8:0] tgt_d;
    logic off_q; // Shutdown latch.
    logic off_d;
    logic [8:0] step_q; // Stepping clock divider.
    vds_pkg::vds_status_t status_q; // Registered status word.
    vds_pkg::vds_status_t status_d;

    // Decode of the sampled code.
    logic [8:0] new_level; // Level of the sampled code.
    logic off_code; // Sampled code is a shutdown code of this table.
    logic acc_fire; // A new code is validated this cycle.
    logic off_fire; // A shutdown code is recognised this cycle.
    logic step_tick; // Stepping clock edge.
    logic step_up; // Slew toward a higher level.
    logic step_dn; // Slew toward a lower level.

    assign new_level = code_level(table_mode, smp_val);
    assign off_code = (mode_8 && smp_val[7:1] == vds_pkg::VR_OFF_HI) ||
                      (table_mode == vds_pkg::VDS_MODE_5BIT &&
                       smp_val[4:0] == vds_pkg::OFF5_CODE);
    // Shutdown codes are never accepted as levels, so the three-sample
    // acceptance cannot pre-empt the four-sample shutdown check.
    assign acc_fire = clk_en && smp_tick && enable && !off_q && !off_code &&
                      (smp_run >= vds_pkg::ACCEPT_RUN) && (!have_q || smp_val != acc_q);
    assign off_fire = clk_en && smp_tick && enable && !off_code ? 1'b0 :
                      clk_en && smp_tick && enable && (smp_run >= vds_pkg::OFF_RUN);
    assign step_tick = clk_en && (step_q == 9'h000);
    assign step_up = step_tick && mode_slew && (dac_q < tgt_q);
    assign step_dn = step_tick && mode_slew && (dac_q > tgt_q);

    // Next target: every validated code becomes the target, any step size.
    assign tgt_d = acc_fire ? new_level : tgt_q;

    // Next reference: direct load in the 8-bit table, one unit per tick otherwise.
    assign dac_d = (acc_fire && mode_8) ? new_level :
                   step_up ? dac_q + 9'h001 :
                   step_dn ? dac_q - 9'h001 :
                   dac_q;

    // Shutdown latch: set by a recognised shutdown code, cleared only by enable low.
    assign off_d = !enable ? 1'b0 : (off_q || off_fire);

    assign status_d.regulate = enable && !off_d;
    assign status_d.off_latched = off_d;
    assign status_d.slewing = mode_slew && (dac_d != tgt_d);

    // Accepted code memory.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            acc_q <= vds_pkg::CODE_RST;
            have_q <= 1'b0;
        end else if (acc_fire) begin
            acc_q <= smp_val;
            have_q <= 1'b1;
        end
    end

    // Reference, target and latch registers.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dac_q <= vds_pkg::LEVEL_RST;
            tgt_q <= vds_pkg::LEVEL_RST;
            off_q <= 1'b0;
            status_q <= '0;
        end else if (clk_en) begin
            dac_q <= dac_d;
            tgt_q <= tgt_d;
            off_q <= off_d;
            status_q <= status_d;
        end
    end

    // Stepping clock divider, free running so a slew starts within one step period.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            step_q <= 9'h000;
        end else if (clk_en) begin
            step_q <= (step_q == 9'h000) ? 9'(STEP_DIV - 1) : step_q - 9'h001;
        end
    end

    assign dac_code = dac_q;
    assign target_code = tgt_q;
    assign status = status_q;

    // Checks on the behaviour above.
    accept_run_a: assert property (@(posedge mclk) disable iff (!reset_n)
        acc_fire |-> (smp_run >= 3'h3) && !off_code)
        else $error("code accepted before three equal samples");

    direct_jump_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (acc_fire && mode_8) |=> (dac_q == $past(new_level)))
        else $error("8-bit table did not load level at once");

    track_rate_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (mode_8 && $past(mode_8) && $changed(dac_q)) |-> $past(acc_fire))
        else $error("8-bit table level moved without a validated code");

    any_step_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (acc_fire && mode_slew) |=> (tgt_q == $past(new_level)))
        else $error("slewing table ignored a validated code");

    slew_unit_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (mode_slew && $past(mode_slew) && $changed(dac_q)) |->
        $past(step_tick) && (dac_q == $past(dac_q) + 9'h001 || dac_q == $past(dac_q) - 9'h001))
        else $error("slew moved by other than one unit or off the step tick");

    slew_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (mode_slew && clk_en && dac_q == tgt_q && !acc_fire) ##1 mode_slew |-> $stable(dac_q))
        else $error("reference moved although it equals the target");

    off_run_a: assert property (@(posedge mclk) disable iff (!reset_n)
        $rose(off_q) |-> $past(smp_run) >= 3'h4 && $past(smp_tick))
        else $error("shutdown recognised before four equal samples");

    off_latch_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (off_q && enable) |=> off_q)
        else $error("off latch released while enable high");

    off_quiet_a: assert property (@(posedge mclk) disable iff (!reset_n)
        status_q.off_latched |-> !status_q.regulate ##1 (!enable || !status_q.regulate))
        else $error("regulation active while latched off");

    mode_react_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (acc_fire && mode_slew && new_level != dac_q) |=> (dac_q != $past(new_level)) ||
        ($past(dac_q) + 9'h001 == $past(new_level)) || ($past(dac_q) == $past(new_level) + 9'h001))
        else $error("slewing table jumped straight to the target");

    jump_c: cover property (@(posedge mclk) disable iff (!reset_n) acc_fire && mode_8);
    // Two up steps in a row show a multi-step slew; the range spans one default step period.
    slew_c: cover property (@(posedge mclk) disable iff (!reset_n) step_up ##[1:300] step_up);
    off_c: cover property (@(posedge mclk) disable iff (!reset_n) $rose(off_q));
    release_c: cover property (@(posedge mclk) disable iff (!reset_n) $fell(off_q));

endmodule

`default_nettype wire
